// ---- hw/tcic_pkg.sv ----
package tcic_pkg;

  // ==========================================================
  // Register map (one 32-bit word per register)
  // ==========================================================
  localparam logic [3:0] TCIC_ADDR_CTRL1 = 4'h0;
  localparam logic [3:0] TCIC_ADDR_CTRL2 = 4'h1;
  localparam logic [3:0] TCIC_ADDR_CTRL3 = 4'h2;
  localparam logic [3:0] TCIC_ADDR_BUF1 = 4'h3;
  localparam logic [3:0] TCIC_ADDR_BUF2 = 4'h4;
  localparam logic [3:0] TCIC_ADDR_BUF3 = 4'h5;
  localparam logic [3:0] TCIC_ADDR_TBASE = 4'h6;
  localparam logic [3:0] TCIC_ADDR_FLAGS = 4'h7;

  // ==========================================================
  // Control register fields and reset values
  // ==========================================================
  localparam int TCIC_REN_BIT = 6;
  localparam int TCIC_MODE_LSB = 0;
  localparam int TCIC_MODE_W = 4;
  localparam logic [7:0] TCIC_CTRL_RST = 8'h00;
  localparam logic [7:0] TCIC_CTRL_MASK = 8'h4F;
  localparam logic [15:0] TCIC_TB_RST = 16'h0000;
  localparam logic [15:0] TCIC_BUF_RST = 16'h0000;
  localparam logic [3:0] TCIC_PRE_RST = 4'h0;
  localparam logic [1:0] TCIC_PHASE_RST = 2'h0;
  localparam logic [1:0] TCIC_PHASE_DETECT = 2'h1;
  localparam logic [1:0] TCIC_PHASE_LOAD = 2'h0;
  localparam logic [3:0] TCIC_PRE4_MAX = 4'h3;
  localparam logic [3:0] TCIC_PRE16_MAX = 4'hF;

  // ==========================================================
  // Channel mode codes
  // ==========================================================
  localparam logic [3:0] TCIC_M_OFF = 4'h0;
  localparam logic [3:0] TCIC_M_FALL = 4'h1;
  localparam logic [3:0] TCIC_M_RISE = 4'h2;
  localparam logic [3:0] TCIC_M_RISE4 = 4'h3;
  localparam logic [3:0] TCIC_M_RISE16 = 4'h4;
  localparam logic [3:0] TCIC_M_PERIOD = 4'h5;
  localparam logic [3:0] TCIC_M_PW_FR = 4'h6;
  localparam logic [3:0] TCIC_M_PW_RF = 4'h7;
  localparam logic [3:0] TCIC_M_CHANGE = 4'h8;
  localparam logic [3:0] TCIC_M_TRIG_F = 4'hE;
  localparam logic [3:0] TCIC_M_TRIG_R = 4'hF;

  typedef enum logic [1:0] {
    TCIC_BUS_IDLE,
    TCIC_BUS_ACK
  } tcic_bus_e;

endpackage

// ---- hw/tcic_capture.sv ----
`timescale 1ns/1ps
`default_nettype none
module tcic_capture
  import tcic_pkg::*;
(
  input wire logic clk_sys, // System clock, 20 MHz
  input wire logic rst, // Async reset, active high
  input wire logic [3:0] avs_address, // Word address
  input wire logic avs_read, // Read request
  input wire logic avs_write, // Write request
  input wire logic [31:0] avs_writedata, // Write data
  input wire logic [3:0] avs_byteenable, // Byte lanes
  output logic [31:0] avs_readdata, // Read data
  output logic avs_waitrequest, // Stall
  input wire logic channel_one_input, // Capture pin 1
  input wire logic channel_two_input, // Capture pin 2
  input wire logic channel_three_input, // Capture pin 3
  output logic trigger_out, // Channel 1 trigger pulse
  output logic [2:0] event_flags, // Sticky event flags
  output logic [15:0] shared_time_base_count // Time base value
);

  // ==========================================================
  // Declarations
  // ==========================================================
  logic [2:0] pin_s1_q, pin_s2_q, pin_prev_q;
  logic [1:0] phase_q;
  logic [7:0] ctrl_q [3];
  logic [15:0] buf_q [3];
  logic [3:0] pre_q [3];
  logic [2:0] armed_q, pw_first_q, period_first_q, invalid_q;
  logic [2:0] flag_q;
  logic [15:0] tb_q;
  logic trig_q;
  tcic_bus_e bus_q;
  logic [31:0] rdata_q;
  logic [2:0] cap_d, rst_d, rise, fall, pre_adv, pre_clr;
  logic trig_d;
  logic detect;
  logic bus_wr, tb_wr;

  // Qualify active edge for a mode; returns capture and reset requests
  function automatic logic [1:0] decode(input logic [3:0] m, input logic r,
      input logic f, input logic ren, input logic [3:0] pre,
      input logic pwf, input logic first);
    logic c;
    logic z;
    c = 1'b0;
    z = 1'b0;
    unique case (m)
      TCIC_M_FALL: c = f;
      TCIC_M_RISE, TCIC_M_PERIOD: c = r;
      TCIC_M_RISE4: c = r && (pre == TCIC_PRE4_MAX || first);
      TCIC_M_RISE16: c = r && (pre == TCIC_PRE16_MAX || first);
      TCIC_M_PW_FR: begin
        c = r || (pwf && f);
        z = f;
      end
      TCIC_M_PW_RF: begin
        c = f || (pwf && r);
        z = r;
      end
      TCIC_M_CHANGE: c = r || f;
      default: c = 1'b0;
    endcase
    if (m != TCIC_M_PW_FR && m != TCIC_M_PW_RF) begin
      z = c && ren;
    end
    return {c, z};
  endfunction

  // Mode field of a control byte
  function automatic logic [3:0] mode_of(input logic [7:0] ctl);
    return ctl[TCIC_MODE_LSB +: TCIC_MODE_W];
  endfunction

  // Accepted bus write aimed at the control word of channel i
  function automatic logic ctrl_hit(input logic wr, input logic [3:0] a,
      input int i);
    return wr && a == 4'(TCIC_ADDR_CTRL1 + i);
  endfunction

  // ==========================================================
  // Pin synchronisers and phase counter
  // ==========================================================
  // Two flops per pin, then an edge history flop
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pin_s1_q <= 3'h0;
      pin_s2_q <= 3'h0;
    end else begin
      pin_s1_q <= {channel_three_input, channel_two_input,
                   channel_one_input};
      pin_s2_q <= pin_s1_q;
    end
  end

  // Four clocks make one instruction cycle
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      phase_q <= TCIC_PHASE_RST;
    end else begin
      phase_q <= phase_q + 2'h1;
    end
  end

  // Edges are sampled only at the second phase
  assign detect = (phase_q == TCIC_PHASE_DETECT);

  // Edge history follows the synced pin at each detect phase
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pin_prev_q <= 3'h0;
    end else if (detect) begin
      pin_prev_q <= pin_s2_q;
    end
  end

  // ==========================================================
  // Per-channel decode
  // ==========================================================
  always_comb begin
    cap_d = 3'h0;
    rst_d = 3'h0;
    rise = 3'h0;
    fall = 3'h0;
    pre_adv = 3'h0;
    pre_clr = 3'h0;
    trig_d = 1'b0;
    for (int i = 0; i < 3; i++) begin
      rise[i] = detect && pin_s2_q[i] && !pin_prev_q[i];
      fall[i] = detect && !pin_s2_q[i] && pin_prev_q[i];
      {cap_d[i], rst_d[i]} = decode(mode_of(ctrl_q[i]), rise[i], fall[i],
          ctrl_q[i][TCIC_REN_BIT], pre_q[i], pw_first_q[i],
          armed_q[i]);
      pre_adv[i] = rise[i] && (mode_of(ctrl_q[i]) == TCIC_M_RISE4 ||
          mode_of(ctrl_q[i]) == TCIC_M_RISE16);
      pre_clr[i] = (mode_of(ctrl_q[i]) == TCIC_M_OFF) ||
          (pre_adv[i] && cap_d[i]);
    end
    // Trigger only on channel 1
    trig_d = (mode_of(ctrl_q[0]) == TCIC_M_TRIG_F && fall[0]) ||
        (mode_of(ctrl_q[0]) == TCIC_M_TRIG_R && rise[0]);
    if (ctrl_q[0][TCIC_REN_BIT] && trig_d) begin
      rst_d[0] = 1'b1;
    end
  end

  // ==========================================================
  // Register bus
  // ==========================================================
  // Writes land at the edge that shows waitrequest low
  assign bus_wr = avs_write && (bus_q == TCIC_BUS_ACK) &&
      avs_byteenable[0];
  assign tb_wr = bus_wr && avs_address == TCIC_ADDR_TBASE;

  // One wait cycle per access, then ack
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      bus_q <= TCIC_BUS_IDLE;
      avs_waitrequest <= 1'b1;
    end else begin
      unique case (bus_q)
        TCIC_BUS_IDLE: begin
          if (avs_read || avs_write) begin
            bus_q <= TCIC_BUS_ACK;
            avs_waitrequest <= 1'b0;
          end
        end
        TCIC_BUS_ACK: begin
          bus_q <= TCIC_BUS_IDLE;
          avs_waitrequest <= 1'b1;
        end
      endcase
    end
  end

  // Read mux captured at request
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdata_q <= 32'h0000_0000;
    end else if (avs_read && bus_q == TCIC_BUS_IDLE) begin
      unique case (avs_address)
        TCIC_ADDR_CTRL1: rdata_q <= {24'h0, ctrl_q[0]};
        TCIC_ADDR_CTRL2: rdata_q <= {24'h0, ctrl_q[1]};
        TCIC_ADDR_CTRL3: rdata_q <= {24'h0, ctrl_q[2]};
        TCIC_ADDR_BUF1: rdata_q <= {15'h0, invalid_q[0], buf_q[0]};
        TCIC_ADDR_BUF2: rdata_q <= {15'h0, invalid_q[1], buf_q[1]};
        TCIC_ADDR_BUF3: rdata_q <= {15'h0, invalid_q[2], buf_q[2]};
        TCIC_ADDR_TBASE: rdata_q <= {16'h0, tb_q};
        TCIC_ADDR_FLAGS: rdata_q <= {29'h0, flag_q};
        default: rdata_q <= 32'h0000_0000;
      endcase
    end
  end
  assign avs_readdata = rdata_q;

  // ==========================================================
  // Control registers and entry tracking
  // ==========================================================
  // Control bytes; a direct mode change is taken as written, so a stray
  // event may follow it unless software switches the channel off first
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 3; i++) begin
        ctrl_q[i] <= TCIC_CTRL_RST;
      end
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (ctrl_hit(bus_wr, avs_address, i)) begin
          ctrl_q[i] <= avs_writedata[7:0] & TCIC_CTRL_MASK;
        end
      end
    end
  end

  // Any mode write arms the channel for an unconditional first capture
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      armed_q <= 3'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (ctrl_hit(bus_wr, avs_address, i)) begin
          armed_q[i] <= 1'b1;
        end else if (cap_d[i]) begin
          armed_q[i] <= 1'b0;
        end
      end
    end
  end

  // Pulse-width entry takes whichever edge comes first
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pw_first_q <= 3'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (ctrl_hit(bus_wr, avs_address, i)) begin
          pw_first_q[i] <= 1'b1;
        end else if (cap_d[i]) begin
          pw_first_q[i] <= 1'b0;
        end
      end
    end
  end

  // Period mode: the capture after a mode write has no start reference
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      period_first_q <= 3'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (ctrl_hit(bus_wr, avs_address, i)) begin
          period_first_q[i] <= 1'b1;
        end else if (cap_d[i]) begin
          period_first_q[i] <= 1'b0;
        end
      end
    end
  end

  // Prescalers; mode change alone does not clear them
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 3; i++) begin
        pre_q[i] <= TCIC_PRE_RST;
      end
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (pre_clr[i]) begin
          pre_q[i] <= TCIC_PRE_RST;
        end else if (pre_adv[i]) begin
          pre_q[i] <= pre_q[i] + 4'h1;
        end
      end
    end
  end

  // ==========================================================
  // Time base, buffers and flags
  // ==========================================================
  // Write wins; capture reset clears after the value is latched
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tb_q <= TCIC_TB_RST;
    end else if (tb_wr) begin
      tb_q <= avs_writedata[15:0];
    end else if (|rst_d) begin
      tb_q <= TCIC_TB_RST;
    end else begin
      tb_q <= tb_q + 16'h0001;
    end
  end

  // Buffers load the time base plus one, the count it steps to at the capture edge unless that capture resets it
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 3; i++) begin
        buf_q[i] <= TCIC_BUF_RST;
      end
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (cap_d[i] && !tb_wr) begin
          buf_q[i] <= tb_q + 16'h0001;
        end
      end
    end
  end

  // First period capture after a mode write is marked unusable
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      invalid_q <= 3'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (cap_d[i] && !tb_wr) begin
          invalid_q[i] <= period_first_q[i] &&
              mode_of(ctrl_q[i]) == TCIC_M_PERIOD;
        end
      end
    end
  end

  // Sticky flags: set wins over clear by write-one
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      flag_q <= 3'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (cap_d[i]) begin
          flag_q[i] <= 1'b1;
        end else if (bus_wr && avs_address == TCIC_ADDR_FLAGS &&
            avs_writedata[i]) begin
          flag_q[i] <= 1'b0;
        end
      end
    end
  end

  // Trigger pulse registered out
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      trig_q <= 1'b0;
    end else begin
      trig_q <= trig_d;
    end
  end

  assign trigger_out = trig_q;
  assign event_flags = flag_q;
  assign shared_time_base_count = tb_q;

endmodule
`default_nettype wire

// ---- testbench/tcic_pin_src.sv ----
`timescale 1ns/1ps
`default_nettype none
// ====
// Edge source standing in for the sensors on the capture pins
module tcic_pin_src (
  output logic [2:0] pins, // Capture pin levels
  input wire logic clk_sys // System clock
);
  // Pins idle low until a waveform is asked for
  initial pins = 3'h0;
  // One pin toggles with given high and low times in clocks; edges move
  // just after a clock edge, so the time base counts in step with them
  task automatic wave(input int ch, input int hi, input int lo,
                      input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_sys) pins[ch] <= 1'b1;
      repeat (hi - 1) @(posedge clk_sys);
      @(posedge clk_sys) pins[ch] <= 1'b0;
      repeat (lo - 1) @(posedge clk_sys);
    end
  endtask
endmodule
`default_nettype wire

// ---- testbench/tcic_capture_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
// ====
// Port-level checks for the capture block
module tcic_capture_chk (
  input wire logic clk_sys, // System clock
  input wire logic rst, // Async reset
  input wire logic [3:0] avs_address, // Word address
  input wire logic avs_write, // Write request
  input wire logic avs_read, // Read request
  input wire logic [31:0] avs_writedata, // Write data
  input wire logic [3:0] avs_byteenable, // Byte lanes
  input wire logic [31:0] avs_readdata, // Read data
  input wire logic avs_waitrequest, // Stall
  input wire logic channel_one_input, // Capture pin 1
  input wire logic trigger_out, // Trigger pulse
  input wire logic [2:0] event_flags, // Event flags
  input wire logic [15:0] shared_time_base_count // Time base
);
  logic [3:0] mode1_q;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Mirror of the channel 1 mode as last accepted on the bus
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst)
      mode1_q <= 4'h0;
    else if (avs_write && !avs_waitrequest && avs_address == 4'h0 &&
             avs_byteenable[0])
      mode1_q <= avs_writedata[3:0];
  end
  // Pin 1 moved within the span a detection may take
  sequence s_pin_moved;
    $past(channel_one_input) != $past(channel_one_input, 10);
  endsequence
  // Channel 1 mode unchanged over the last eight clocks
  sequence s_mode_held;
    mode1_q == $past(mode1_q, 8);
  endsequence
  // ====
  // Assertions
  ctrl_zero_a: assert property (avs_read && !avs_waitrequest &&
    avs_address < 4'h3 |-> (avs_readdata & 32'hFFFFFFB0) == 32'h0)
    else $error("control read shows unimplemented bits set");
  tb_step_a: assert property (shared_time_base_count !=
    $past(shared_time_base_count) + 16'h1 |-> shared_time_base_count ==
    16'h0 || $past(avs_write) || $past(avs_write, 2))
    else $error("time base jumped without reset or write");
  flag_sticky_a: assert property (|($past(event_flags) &
    ~event_flags) |-> $past(avs_write) || $past(avs_write, 2))
    else $error("event flag cleared without a write");
  flag_cause_a: assert property ($rose(event_flags[0]) |->
    s_pin_moved) else $error("channel 1 flag without pin edge");
  off_quiet_a: assert property ((mode1_q == 4'h0 ||
    (mode1_q > 4'h8 && mode1_q < 4'hE)) and s_mode_held |->
    !$rose(event_flags[0])) else $error("idle channel 1 raised flag");
  trig_flagless_a: assert property (mode1_q[3:1] == 3'h7
    and s_mode_held |-> !$rose(event_flags[0]))
    else $error("trigger mode raised channel 1 flag");
  trig_mode_a: assert property (trigger_out and s_mode_held |->
    mode1_q[3:1] == 3'h7) else $error("trigger outside trigger mode");
  trig_cause_a: assert property (trigger_out |-> s_pin_moved)
    else $error("trigger without pin edge");
  trig_pulse_a: assert property (trigger_out |=> !trigger_out)
    else $error("trigger longer than one clock");
endmodule
bind tcic_capture tcic_capture_chk u_chk (.clk_sys(clk_sys), .rst(rst),
  .avs_address(avs_address), .avs_write(avs_write), .avs_read(avs_read),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .channel_one_input(channel_one_input), .trigger_out(trigger_out),
  .event_flags(event_flags),
  .shared_time_base_count(shared_time_base_count));
`default_nettype wire

// ---- testbench/test_tcic_capture.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin \
  n_mismatch++; $display("wrong value %s expected %0h seen %0h", nm, \
  ex, got); end end
module test_tcic_capture;
  import tcic_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [2:0] pins;
  logic trigger_out;
  logic [2:0] event_flags;
  logic [15:0] shared_time_base_count;
  logic [31:0] rd;
  int n_mismatch = 0;
  int checks = 0;
  int n_trig = 0;
  // ====
  // Clock, trigger count, design and edge source
  always #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (trigger_out === 1'b1) n_trig++;
  tcic_capture DUT (.clk_sys(clk_sys), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .channel_one_input(pins[0]),
    .channel_two_input(pins[1]), .channel_three_input(pins[2]),
    .trigger_out(trigger_out), .event_flags(event_flags),
    .shared_time_base_count(shared_time_base_count));
  tcic_pin_src u_src (.pins(pins), .clk_sys(clk_sys));
  // ====
  // One bus transfer, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] wd, input logic [3:0] be);
    @(posedge clk_sys);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= wd;
    avs_byteenable <= be;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  // Switch off, clear flags, set mode, play a waveform, read the buffer
  task automatic run(input int ch, input logic [7:0] ctl, input int hi,
                     input int lo, input int n);
    bus(1'b1, TCIC_ADDR_CTRL1 + 4'(ch), 32'h0, 4'h1);
    bus(1'b1, TCIC_ADDR_FLAGS, 32'h7, 4'h1);
    bus(1'b1, TCIC_ADDR_CTRL1 + 4'(ch), {24'h0, ctl}, 4'h1);
    n_trig = 0;
    u_src.wave(ch, hi, lo, n);
    bus(1'b0, TCIC_ADDR_BUF1 + 4'(ch), 32'h0, 4'hF);
  endtask
  // Reset values, masked bits, byte lanes and an unmapped word
  task automatic t_regs();
    for (int c = 0; c < 3; c++) begin
      bus(1'b0, TCIC_ADDR_CTRL1 + 4'(c), 32'h0, 4'hF);
      `CHK("ctrl reset", 32'h0, rd)
    end
    bus(1'b1, TCIC_ADDR_CTRL2, 32'hFF, 4'h1);
    bus(1'b0, TCIC_ADDR_CTRL2, 32'h0, 4'hF);
    `CHK("ctrl mask", 32'h4F, rd)
    bus(1'b1, TCIC_ADDR_CTRL2, 32'h0, 4'h0);
    bus(1'b0, TCIC_ADDR_CTRL2, 32'h0, 4'hF);
    `CHK("ctrl lanes", 32'h4F, rd)
    bus(1'b1, 4'h9, 32'hFF, 4'hF);
    bus(1'b0, 4'h9, 32'h0, 4'hF);
    `CHK("unmapped", 32'h0, rd)
    bus(1'b1, TCIC_ADDR_TBASE, 32'h1234, 4'hF);
    bus(1'b0, TCIC_ADDR_TBASE, 32'h0, 4'hF);
    `CHK("tb write", 1'b1, rd[15:0] > 16'h1234 && rd[15:0] < 16'h1240)
  endtask
  // Edge modes with prescalers on all three channels, reset on capture
  task automatic t_edges();
    logic [3:0] m [4] = '{4'h1, 4'h2, 4'h3, 4'h4};
    int n [4] = '{3, 3, 9, 17};
    logic [15:0] e [4] = '{16'h0020, 16'h0020, 16'h0080, 16'h0200};
    for (int i = 0; i < 4; i++) begin
      run(i % 3, {4'h4, m[i]}, 16, 16, n[i]);
      `CHK("edge buf", e[i], rd[15:0])
      `CHK("edge flag", 3'(1 << (i % 3)), event_flags)
    end
  endtask
  // Period mode: first capture marked invalid, later ones valid
  task automatic t_period();
    run(1, 8'h45, 16, 16, 1);
    `CHK("period first", 1'b1, rd[16])
    u_src.wave(1, 16, 16, 2);
    bus(1'b0, TCIC_ADDR_BUF2, 32'h0, 4'hF);
    `CHK("period value", 17'h00020, rd[16:0])
  endtask
  // Pulse width both ways, and capture on every change
  task automatic t_widths();
    run(2, 8'h06, 24, 40, 4);
    `CHK("low width", 16'h0028, rd[15:0])
    run(0, 8'h07, 24, 40, 4);
    `CHK("high width", 16'h0018, rd[15:0])
    `CHK("width flag", 3'h1, event_flags)
    run(1, 8'h48, 16, 16, 3);
    `CHK("change buf", 16'h0010, rd[15:0])
    `CHK("change flag", 3'h2, event_flags)
  endtask
  // Trigger modes on channel 1, the same codes elsewhere, idle codes
  task automatic t_trig();
    logic [7:0] ctl [5] = '{8'h0F, 8'h0E, 8'h4F, 8'h49, 8'h40};
    int ch [5] = '{0, 0, 1, 2, 0};
    int nt [5] = '{4, 4, 0, 0, 0};
    for (int i = 0; i < 5; i++) begin
      run(ch[i], ctl[i], 16, 16, 4);
      `CHK("trig count", nt[i], n_trig)
      `CHK("trig idle", 1'b0, trigger_out)
      `CHK("quiet flag", 3'h0, event_flags)
    end
  endtask
  // Verdict and end of run
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Watchdog against a hung handshake
  initial begin
    #1000000;
    n_mismatch++;
    print_verdict();
  end
  // Main sequence
  initial begin
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    t_regs();
    t_edges();
    t_period();
    t_widths();
    t_trig();
    print_verdict();
  end
endmodule
`default_nettype wire
